// *** inc/mark_latch_pkg.sv ***
// constants, types and helpers shared by the mark detection latch
package mark_latch_pkg;
  localparam int NUM_CH        = 32;
  localparam int CH_W          = 5;
  localparam int CNT_W         = 14;
  localparam int CLK_PERIOD_NS = 5;
  localparam int OP_CYCLE_NS   = 222000;
  localparam int OP_CYCLE_US   = 222;
  localparam int COMP_MAX_US   = 5000000;
  localparam int COMP_MIN_US   = -5000000;
  localparam int DET_MAX       = 8192;

  // register byte offsets
  localparam logic [7:0] OFS_CHAN_SEL  = 8'h00;
  localparam logic [7:0] OFS_SIG_CFG   = 8'h04;
  localparam logic [7:0] OFS_DATA_CFG  = 8'h08;
  localparam logic [7:0] OFS_COMP      = 8'h0C;
  localparam logic [7:0] OFS_RING      = 8'h10;
  localparam logic [7:0] OFS_UPPER_LO  = 8'h14;
  localparam logic [7:0] OFS_UPPER_HI  = 8'h18;
  localparam logic [7:0] OFS_LOWER_LO  = 8'h1C;
  localparam logic [7:0] OFS_LOWER_HI  = 8'h20;
  localparam logic [7:0] OFS_DET_NUM   = 8'h24;
  localparam logic [7:0] OFS_MODE_WORD = 8'h28;
  localparam logic [7:0] OFS_DET_COUNT = 8'h2C;
  localparam logic [7:0] OFS_LIVE      = 8'h30;
  localparam logic [7:0] OFS_MON_LO    = 8'h34;
  localparam logic [7:0] OFS_MON_HI    = 8'h38;

  localparam logic [63:0] SIGN64 = 64'h8000_0000_0000_0000;

  typedef enum logic [1:0] {SRC_BUILTIN, SRC_EXTERNAL, SRC_BITDEV} src_t;
  typedef enum logic [1:0] {DT_INT16, DT_INT32, DT_FLOAT64} dtype_t;
  typedef enum logic [1:0] {EST_NORMAL, EST_RING, EST_OFF} est_t;
  typedef enum logic [1:0] {MODE_CONT, MODE_COUNT, MODE_RING, MODE_WORD} mode_t;

  typedef struct packed {
    logic        bit_unused;
    logic [4:0]  bit_sel;
    logic [2:0]  signal_sel;
    logic [1:0]  module_sel;
    logic [1:0]  din_sel;
    src_t        src;
    logic        falling;
    logic        enable;
  } sig_cfg_t;

  typedef struct packed {
    mode_t       mode;
    logic        range_en;
    est_t        est;
    dtype_t      dtype;
    logic [4:0]  axis_sel;
    logic        from_word;
  } data_cfg_t;

  typedef struct packed {
    logic [CH_W-1:0]  chan;
    logic [CNT_W-1:0] slot;
    logic [63:0]      data;
  } store_t;

  // sign-extend a word by data type; float passes whole
  function automatic logic [63:0] sext(input logic [63:0] v, input dtype_t dt);
    case (dt)
      DT_INT16: sext = {{48{v[15]}}, v[15:0]};
      DT_INT32: sext = {{32{v[31]}}, v[31:0]};
      default:  sext = v;
    endcase
  endfunction

  // map a value onto an unsigned key whose order matches the value order
  function automatic logic [63:0] order_key(input logic [63:0] v, input dtype_t dt);
    if (dt == DT_FLOAT64 && v[63]) order_key = ~v;
    else if (dt == DT_FLOAT64) order_key = v | SIGN64;
    else order_key = v ^ SIGN64;
  endfunction
endpackage

// *** hdl/mark_value_estimator.sv ***
// estimate, ring wrap and range check of one latched value
`timescale 1ns/1ps
module mark_value_estimator (
  // clock for checks only
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // configuration
  input  wire mark_latch_pkg::dtype_t dtype_i,
  input  wire mark_latch_pkg::est_t   est_i,
  input  wire logic signed [31:0]    comp_i,
  input  wire logic [31:0]           ring_i,
  input  wire logic                  range_en_i,
  input  wire logic [63:0]           upper_i,
  input  wire logic [63:0]           lower_i,
  // samples
  input  wire logic [63:0]           raw_i,
  input  wire logic [63:0]           prev_i,
  // result
  output logic [63:0]                value_o,
  output logic                       in_range_o
);
  wire logic [63:0] cur = mark_latch_pkg::sext(raw_i, dtype_i);
  wire logic [63:0] old = mark_latch_pkg::sext(prev_i, dtype_i);

  // clamp compensation, forced to zero when estimate is off
  wire logic signed [31:0] comp_eff =
    (est_i == mark_latch_pkg::EST_OFF) ? 32'sh0000_0000 :
    (comp_i > mark_latch_pkg::COMP_MAX_US) ? 32'(mark_latch_pkg::COMP_MAX_US) :
    (comp_i < mark_latch_pkg::COMP_MIN_US) ? 32'(mark_latch_pkg::COMP_MIN_US) : comp_i;

  // linear extrapolation over one operation cycle; float values are not extrapolated
  wire logic signed [63:0] delta = $signed(cur) - $signed(old);
  wire logic signed [63:0] shift = 64'((delta * comp_eff) / mark_latch_pkg::OP_CYCLE_US);
  wire logic        do_est = (dtype_i != mark_latch_pkg::DT_FLOAT64) && (est_i != mark_latch_pkg::EST_OFF);
  wire logic signed [63:0] est = do_est ? $signed(cur) + shift : $signed(cur);

  // single-step wrap into 0..ring-1, enough since shift stays small
  wire logic signed [63:0] ring = {32'h0000_0000, ring_i};
  wire logic        do_wrap = do_est && (est_i == mark_latch_pkg::EST_RING);
  assign value_o = !do_wrap ? est : (est >= ring) ? est - ring :
                   (est < 0) ? est + ring : est;

  // range check on an order-preserving key
  wire logic [63:0] k_val = mark_latch_pkg::order_key(value_o, dtype_i);
  wire logic [63:0] k_up  = mark_latch_pkg::order_key(mark_latch_pkg::sext(upper_i, dtype_i), dtype_i);
  wire logic [63:0] k_lo  = mark_latch_pkg::order_key(mark_latch_pkg::sext(lower_i, dtype_i), dtype_i);
  assign in_range_o = !range_en_i || (k_val <= k_up && k_val >= k_lo);

  a_est_off_plain: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    est_i == mark_latch_pkg::EST_OFF |-> value_o == cur) else $error("estimate off changed value");
  a_comp_clamped: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    comp_eff <= mark_latch_pkg::COMP_MAX_US && comp_eff >= mark_latch_pkg::COMP_MIN_US)
    else $error("compensation outside limits");
endmodule

// *** hdl/mark_detection_latch.sv ***
// mark detection latch: 32 channels, avalon-mm register slave, store stream out
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module mark_detection_latch #(
  parameter int OP_CYCLE_CLKS = mark_latch_pkg::OP_CYCLE_NS / mark_latch_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         arst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]                   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic [31:0]                       avs_readdata_o,
  output logic                              avs_waitrequest_o,
  // mark inputs
  input  wire logic [3:0]                   builtin_digital_input_i,
  input  wire logic [31:0]                  external_proximity_input_i,
  input  wire logic [31:0]                  special_bit_device_i,
  // latch sources
  input  wire logic [31:0][31:0]            axis_value_i,
  input  wire logic [31:0][63:0]            word_source_i,
  // store stream and live state
  output logic                              store_valid_o,
  output mark_latch_pkg::store_t            store_o,
  output logic [31:0]                       mark_state_o
);
  localparam int N = mark_latch_pkg::NUM_CH;
  localparam int SW = $bits(mark_latch_pkg::sig_cfg_t);
  localparam int DW = $bits(mark_latch_pkg::data_cfg_t);
  localparam int CW = mark_latch_pkg::CNT_W;
  localparam logic [CW-1:0] CNT_MAX = '1;

  typedef enum logic {ST_IDLE, ST_SCAN} scan_st_t;

  // per-channel configuration storage
  mark_latch_pkg::sig_cfg_t  sig_q  [N];
  mark_latch_pkg::data_cfg_t dat_q  [N];
  logic signed [31:0]        comp_q [N];
  logic [31:0]               ring_q [N];
  logic [63:0]               up_q   [N];
  logic [63:0]               lo_q   [N];
  logic [CW-1:0]             num_q  [N];
  logic signed [31:0]        mw_q   [N];
  logic [CW-1:0]             cnt_q  [N];
  logic [63:0]               prev_q [N];
  logic [63:0]               mon_q  [N];
  logic [4:0]                sel_q;
  logic                      ack_q;
  logic [31:0]               rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, pins only; bit devices share our clock
  logic [3:0]  din_s1_q, din_s2_q;
  logic [31:0] ext_s1_q, ext_s2_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      ext_s1_q <= '0;
      ext_s2_q <= '0;
    end else begin
      din_s1_q <= builtin_digital_input_i;
      din_s2_q <= din_s1_q;
      ext_s1_q <= external_proximity_input_i;
      ext_s2_q <= ext_s1_q;
    end
  end

  // live level of each channel's selected source
  function automatic logic chan_level(input mark_latch_pkg::sig_cfg_t c, input logic [3:0] d,
                                      input logic [31:0] e, input logic [31:0] b);
    case (c.src)
      mark_latch_pkg::SRC_BUILTIN:  chan_level = d[c.din_sel];
      mark_latch_pkg::SRC_EXTERNAL: chan_level = e[{c.module_sel, c.signal_sel}];
      default:                      chan_level = b[c.bit_sel];
    endcase
  endfunction

  logic [N-1:0] level, lvl_q, pend_q, edge_hit;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      level[i] = chan_level(sig_q[i], din_s2_q, ext_s2_q, special_bit_device_i);
      edge_hit[i] = sig_q[i].enable && (sig_q[i].falling ? (lvl_q[i] && !level[i])
                                                        : (!lvl_q[i] && level[i]));
    end
  end
  assign mark_state_o = lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // operation cycle divider and channel scan; needs OP_CYCLE_CLKS of at least N
  logic [31:0] div_q;
  logic [4:0]  idx_q;
  scan_st_t    st_q;
  wire logic   tick = (div_q == 32'(OP_CYCLE_CLKS - 1));
  wire logic   scan = (st_q == ST_SCAN);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q  <= '0;
      st_q   <= ST_IDLE;
      idx_q  <= '0;
      lvl_q  <= '0;
      pend_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 32'd1;
      if (tick) begin
        lvl_q  <= level;
        pend_q <= edge_hit;
        st_q   <= ST_SCAN;
        idx_q  <= '0;
      end else if (scan) begin
        pend_q[idx_q] <= 1'b0;
        idx_q <= idx_q + 5'd1;
        if (idx_q == 5'(N - 1)) st_q <= ST_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // value of the scanned channel
  mark_latch_pkg::data_cfg_t dc;
  assign dc = dat_q[idx_q];
  wire logic [31:0] axis_v = axis_value_i[dc.axis_sel];
  wire logic [63:0] raw = dc.from_word ? word_source_i[idx_q] : {{32{axis_v[31]}}, axis_v};
  wire mark_latch_pkg::dtype_t eff_dt = dc.from_word ? dc.dtype : mark_latch_pkg::DT_INT32;
  wire mark_latch_pkg::est_t eff_est = dc.from_word ? dc.est : mark_latch_pkg::EST_NORMAL;
  logic [63:0] est_val;
  logic        in_range;

  mark_value_estimator u_est (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .dtype_i    (eff_dt),
    .est_i      (eff_est),
    .comp_i     (comp_q[idx_q]),
    .ring_i     (ring_q[idx_q]),
    .range_en_i (dc.range_en),
    .upper_i    (up_q[idx_q]),
    .lower_i    (lo_q[idx_q]),
    .raw_i      (raw),
    .prev_i     (prev_q[idx_q]),
    .value_o    (est_val),
    .in_range_o (in_range)
  );

  // resolve the mode: word value 0 continuous, +n count, -n ring
  wire logic signed [31:0] mw = mw_q[idx_q];
  wire logic mode_dis = (dc.mode == mark_latch_pkg::MODE_WORD) &&
                        (mw < -mark_latch_pkg::DET_MAX || mw > mark_latch_pkg::DET_MAX);
  wire mark_latch_pkg::mode_t eff_mode = (dc.mode != mark_latch_pkg::MODE_WORD) ? dc.mode :
    (mw == 0) ? mark_latch_pkg::MODE_CONT : (mw > 0) ? mark_latch_pkg::MODE_COUNT : mark_latch_pkg::MODE_RING;
  wire logic [31:0] mw_abs = (mw < 0) ? 32'(-mw) : 32'(mw);
  wire logic [CW-1:0] n = (dc.mode == mark_latch_pkg::MODE_WORD) ? CW'(mw_abs) : num_q[idx_q];
  wire logic [CW-1:0] cnt = cnt_q[idx_q];
  wire logic full = (eff_mode == mark_latch_pkg::MODE_COUNT) && (cnt >= n);
  wire logic accept = scan && pend_q[idx_q] && !mode_dis && in_range && !full;
  wire logic [CW-1:0] cnt_inc = cnt + CW'(1);
  wire logic [CW-1:0] cnt_next =
    (eff_mode == mark_latch_pkg::MODE_RING) ? ((cnt_inc >= n) ? '0 : cnt_inc) :
    (eff_mode == mark_latch_pkg::MODE_CONT && cnt == CNT_MAX) ? cnt : cnt_inc;
  wire logic [CW-1:0] slot = (eff_mode == mark_latch_pkg::MODE_CONT) ? '0 : cnt;

  // store stream, registered; monitor and history follow every scan
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      store_valid_o <= 1'b0;
      store_o       <= '0;
    end else begin
      store_valid_o <= accept;
      if (accept) store_o <= '{chan: idx_q, slot: slot, data: est_val};
    end
  end
  // history cleared so the first estimate after reset never sees an unknown
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < N; i++) begin
        prev_q[i] <= '0;
        mon_q[i]  <= '0;
      end
    end else if (scan) begin
      prev_q[idx_q] <= raw;
      mon_q[idx_q]  <= est_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer
  wire logic req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_q;
  assign avs_readdata_o = rdata_q;
  wire logic [7:0] a = avs_address_i;
  logic [31:0] rd_word;
  always_comb begin
    case (a)
      mark_latch_pkg::OFS_CHAN_SEL:  rd_word = 32'(sel_q);
      mark_latch_pkg::OFS_SIG_CFG:   rd_word = 32'(sig_q[sel_q]);
      mark_latch_pkg::OFS_DATA_CFG:  rd_word = 32'(dat_q[sel_q]);
      mark_latch_pkg::OFS_COMP:      rd_word = comp_q[sel_q];
      mark_latch_pkg::OFS_RING:      rd_word = ring_q[sel_q];
      mark_latch_pkg::OFS_UPPER_LO:  rd_word = up_q[sel_q][31:0];
      mark_latch_pkg::OFS_UPPER_HI:  rd_word = up_q[sel_q][63:32];
      mark_latch_pkg::OFS_LOWER_LO:  rd_word = lo_q[sel_q][31:0];
      mark_latch_pkg::OFS_LOWER_HI:  rd_word = lo_q[sel_q][63:32];
      mark_latch_pkg::OFS_DET_NUM:   rd_word = 32'(num_q[sel_q]);
      mark_latch_pkg::OFS_MODE_WORD: rd_word = mw_q[sel_q];
      mark_latch_pkg::OFS_DET_COUNT: rd_word = 32'(cnt_q[sel_q]);
      mark_latch_pkg::OFS_LIVE:      rd_word = lvl_q;
      mark_latch_pkg::OFS_MON_LO:    rd_word = mon_q[sel_q][31:0];
      mark_latch_pkg::OFS_MON_HI:    rd_word = mon_q[sel_q][63:32];
      default:                       rd_word = '0;
    endcase
  end
  logic [31:0] wd;
  always_comb begin
    for (int b = 0; b < 4; b++) wd[b*8 +: 8] = avs_byteenable_i[b] ? avs_writedata_i[b*8 +: 8] : rd_word[b*8 +: 8];
  end
  wire logic wr = avs_write_i && ack_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req && !ack_q;
      if (avs_read_i && !ack_q) rdata_q <= rd_word;
    end
  end

  // configuration writes for the selected channel
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_q <= '0;
      for (int i = 0; i < N; i++) begin
        sig_q[i]  <= '0;
        dat_q[i]  <= '0;
        comp_q[i] <= '0;
        ring_q[i] <= '0;
        up_q[i]   <= '0;
        lo_q[i]   <= '0;
        num_q[i]  <= '0;
        mw_q[i]   <= '0;
      end
    end else if (wr) begin
      case (a)
        mark_latch_pkg::OFS_CHAN_SEL:  sel_q <= wd[4:0];
        mark_latch_pkg::OFS_SIG_CFG:   sig_q[sel_q] <= mark_latch_pkg::sig_cfg_t'(wd[SW-1:0]);
        mark_latch_pkg::OFS_DATA_CFG:  dat_q[sel_q] <= mark_latch_pkg::data_cfg_t'(wd[DW-1:0]);
        mark_latch_pkg::OFS_COMP:      comp_q[sel_q] <= wd;
        mark_latch_pkg::OFS_RING:      ring_q[sel_q] <= wd;
        mark_latch_pkg::OFS_UPPER_LO:  up_q[sel_q][31:0] <= wd;
        mark_latch_pkg::OFS_UPPER_HI:  up_q[sel_q][63:32] <= wd;
        mark_latch_pkg::OFS_LOWER_LO:  lo_q[sel_q][31:0] <= wd;
        mark_latch_pkg::OFS_LOWER_HI:  lo_q[sel_q][63:32] <= wd;
        mark_latch_pkg::OFS_DET_NUM:   num_q[sel_q] <= wd[CW-1:0];
        mark_latch_pkg::OFS_MODE_WORD: mw_q[sel_q] <= wd;
        default: ;
      endcase
    end
  end

  // detection counters: a detection wins over a host write in the same cycle
  wire logic cnt_wr = wr && (a == mark_latch_pkg::OFS_DET_COUNT) && !(accept && sel_q == idx_q);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < N; i++) cnt_q[i] <= '0;
    end else begin
      if (accept) cnt_q[idx_q] <= cnt_next;
      if (cnt_wr) cnt_q[sel_q] <= wd[CW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_bus_one_wait: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("waitrequest held too long");
  a_store_follows: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept |=> store_valid_o && store_o.data == $past(est_val)) else $error("store missing");
  a_range_drop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    scan && !in_range |=> !store_valid_o) else $error("out of range value stored");
  a_count_stop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    scan && full |=> !store_valid_o) else $error("latched past the count");
  a_ring_slot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && eff_mode == mark_latch_pkg::MODE_RING |-> slot < n) else $error("ring slot beyond size");
  a_mode_disable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    mode_dis |-> !accept) else $error("disabled channel latched");
  a_cont_slot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && eff_mode == mark_latch_pkg::MODE_CONT |=> store_o.slot == '0) else $error("continuous slot");
  a_rise_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tick && sig_q[0].enable && !sig_q[0].falling && !lvl_q[0] && level[0] |=> pend_q[0])
    else $error("rising edge missed");
  c_ring_wrap: cover property (@(posedge clk_i) accept && eff_mode == mark_latch_pkg::MODE_RING && cnt_next == '0);
  c_count_full: cover property (@(posedge clk_i) scan && pend_q[idx_q] && full);
  c_store: cover property (@(posedge clk_i) store_valid_o);
endmodule

// *** verif/mark_sensor_model.sv ***
// mark sensor on a built-in digital input, with a short fixed response delay
`timescale 1ns/1ps
module mark_sensor_model (
  // clock and command
  input  wire logic clk_i,
  input  wire logic mark_i,
  // sensor pin
  output logic      pin_o
);
  logic [2:0] dly_q;
  // a real sensor lags the mark by a few cycles; the pin is push-pull, never released
  always_ff @(posedge clk_i) begin
    dly_q <= {dly_q[1:0], mark_i};
  end
  assign pin_o = dly_q[2];
endmodule

// *** verif/test_mark_detection_latch.sv ***
// self-checking bench of the mark detection latch with a queue-based store model
`timescale 1ns/1ps
module test_mark_detection_latch;
  logic clk_i = 0, arst_n_i = 0, rd = 0, wr = 0, mark = 0, pin, store_valid_o;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q, mark_state_o, ext = 0, bits = 0;
  logic [31:0][31:0] axis = '0;
  logic [31:0][63:0] words = '0;
  logic wait_o;
  mark_latch_pkg::store_t store_o;
  mark_latch_pkg::store_t expq[$];
  int miscompares = 0, n_compared = 0, cnt = 0, mode = 0, num = 1, rng = 0, wrap = 0, seed = 32'hab50_f691;
  always #2.5 clk_i = ~clk_i;
  mark_sensor_model sens_u (.clk_i(clk_i), .mark_i(mark), .pin_o(pin));
  mark_detection_latch #(.OP_CYCLE_CLKS(64)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .builtin_digital_input_i({3'h0, pin}), .external_proximity_input_i(ext), .special_bit_device_i(bits),
    .axis_value_i(axis), .word_source_i(words), .store_valid_o(store_valid_o), .store_o(store_o),
    .mark_state_o(mark_state_o));
  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon cycle: held until waitrequest is seen low, released at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask
  // store stream is checked against the model at every pulse
  always @(negedge clk_i) if (store_valid_o === 1'b1) begin
    if (expq.size() == 0) chk("unexpected store", 0, 1);
    else chk("store", expq.pop_front(), store_o);
  end
  // mark pulse high then low, 140 clocks each (two or three ticks), value set beforehand
  task automatic pulse(input int v);
    mark_latch_pkg::store_t s;
    int e;
    e = (wrap > 0 && v >= wrap) ? v - wrap : v;
    words[0] <= {$random(seed), v};
    axis[2] <= v;
    s.chan = 0;
    s.data = {{32{e[31]}}, e};
    s.slot = (mode == 2 || mode == 1) ? cnt : 0;
    if ((rng == 0 || (v <= 100 && v >= -100)) && mode != 3 && !(mode == 1 && cnt >= num)) begin
      expq.push_back(s);
      cnt = (mode == 2) ? (cnt + 1) % num : cnt + 1;
    end
    mark <= 1;
    bits[0] <= 1;
    repeat (140) @(posedge clk_i);
    chk("live level", 1, mark_state_o[0]);
    mark <= 0;
    bits[0] <= 0;
    repeat (140) @(posedge clk_i);
  endtask
  task automatic setup(input int m, input int r, input logic [31:0] cfg);
    mode = m;
    rng = r;
    cnt = 0;
    bus(1, mark_latch_pkg::OFS_DATA_CFG, cfg);
    bus(1, mark_latch_pkg::OFS_DET_COUNT, 0);
  endtask
  task automatic end_of_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    ext <= $random(seed);
    for (int i = 0; i < 32; i++) axis[i] <= $random(seed);
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1;
    bus(0, mark_latch_pkg::OFS_DET_COUNT, 0);
    chk("counter reset", 0, q);
    bus(0, 8'hFC, 0);
    chk("unmapped read", 0, q);
    bus(1, mark_latch_pkg::OFS_CHAN_SEL, 0);
    bus(1, mark_latch_pkg::OFS_SIG_CFG, 32'h0000_0009);
    bus(1, mark_latch_pkg::OFS_COMP, 32'h0000_03e8);
    setup(0, 0, 32'h0000_0241);
    pulse($random(seed) % 100);
    pulse(-7);
    bus(0, mark_latch_pkg::OFS_DET_COUNT, 0);
    chk("counter", cnt, q);
    num = 2;
    bus(1, mark_latch_pkg::OFS_DET_NUM, 2);
    bus(1, mark_latch_pkg::OFS_UPPER_LO, 100);
    bus(1, mark_latch_pkg::OFS_UPPER_HI, 0);
    bus(1, mark_latch_pkg::OFS_LOWER_LO, -100);
    bus(1, mark_latch_pkg::OFS_LOWER_HI, 32'hffff_ffff);
    setup(1, 1, 32'h0000_0E41);
    pulse(5);
    pulse(500);
    pulse($random(seed) % 100);
    pulse(9);
    bus(1, mark_latch_pkg::OFS_DET_COUNT, 0);
    cnt = 0;
    pulse(-3);
    setup(2, 0, 32'h0000_1241);
    for (int i = 0; i < 3; i++) pulse(i * 11);
    bus(1, mark_latch_pkg::OFS_MODE_WORD, 9000);
    setup(3, 0, 32'h0000_1A41);
    pulse(4);
    bus(1, mark_latch_pkg::OFS_SIG_CFG, 32'h0000_0003);
    setup(0, 0, 32'h0000_0241);
    pulse(42);
    bus(1, mark_latch_pkg::OFS_COMP, 0);
    bus(1, mark_latch_pkg::OFS_RING, 50);
    wrap = 50;
    setup(0, 0, 32'h0000_0141);
    pulse(70);
    pulse(12);
    wrap = 0;
    setup(0, 0, 32'h0000_0004);
    pulse(-77);
    bus(0, mark_latch_pkg::OFS_MON_LO, 0);
    chk("monitor", 32'hffff_ffb3, q);
    chk("pending stores", 0, expq.size());
    end_of_test();
  end
endmodule
